// file: hdl/lcdsd_cfg.svh
// Register offsets, field positions, reset values and sizes of the LCD segment driver.
`ifndef LCDSD_CFG_SVH
`define LCDSD_CFG_SVH
`define LCDSD_OFF_CTRL 8'h00
`define LCDSD_OFF_PINSEL 8'h04
`define LCDSD_OFF_STATUS 8'h08
`define LCDSD_OFF_MEM 8'h10
`define LCDSD_CTRL_RST 8'h00
`define LCDSD_PINSEL_RST 7'h00
`define LCDSD_STAT_SUPPLY 0
`define LCDSD_STAT_SLOT_LO 1
`define LCDSD_STAT_HALF 3
`define LCDSD_FIRST_GROUP_SEGS 16
`define LCDSD_GROUP_STEP 4
`define LCDSD_NUM_SEG 32
`define LCDSD_SHARED_SEG 28
`endif

// file: hdl/lcdsd_pkg.sv
// Types shared by the LCD segment driver.
package lcdsd_pkg;
   typedef enum logic [2:0] {LCDSD_LV_ZERO, LCDSD_LV_V1, LCDSD_LV_V2, LCDSD_LV_V3,
      LCDSD_LV_V4, LCDSD_LV_V5} lcdsd_level_t;
   typedef struct packed {
      lcdsd_level_t first;
      lcdsd_level_t second;
   } lcdsd_pair_t;
   typedef struct packed {
      lcdsd_level_t level_a;
      lcdsd_level_t level_b;
      lcdsd_level_t level_c;
      lcdsd_level_t level_d;
   } lcdsd_drive_t;
   typedef struct packed {
      logic oscillator_disable;
      logic [2:0] segment_port_group_select;
      logic [1:0] mux_rate_select;
      logic segments_global_on;
      logic display_module_on;
   } lcdsd_ctrl_t;
endpackage

// file: hdl/lcdsd_top.sv
// LCD segment and common line driver with an APB register slave.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "lcdsd_cfg.svh"

module lcdsd_top #(
   parameter int NUM_SEG = `LCDSD_NUM_SEG,
   parameter int SHARED_SEG = `LCDSD_SHARED_SEG
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_timing_clock,
   output logic ladder_supply_out,
   output lcdsd_pkg::lcdsd_drive_t drive_levels,
   output lcdsd_pkg::lcdsd_level_t [3:0] common_level,
   output lcdsd_pkg::lcdsd_level_t [NUM_SEG-1:0] segment_level,
   output logic [3:0] common_pin_lcd,
   output logic [2:0] tap_pin_lcd,
   output logic [NUM_SEG-1:0] segment_pin_lcd
);
   localparam int MEM_WORDS = (NUM_SEG * 4 + 31) / 32;

   // ==========================================================
   // Register file
   lcdsd_pkg::lcdsd_ctrl_t ctrl;
   logic [6:0] pin_function_select;
   logic [MEM_WORDS-1:0][31:0] mem;
   logic [1:0] slot;
   logic half;
   logic ftc_q;

   wire access = psel && penable;
   wire wr = access && pwrite;
   wire hit_ctrl = paddr == `LCDSD_OFF_CTRL;
   wire hit_pinsel = paddr == `LCDSD_OFF_PINSEL;
   wire hit_status = paddr == `LCDSD_OFF_STATUS;
   wire [7:0] mem_rel = paddr - `LCDSD_OFF_MEM;
   wire hit_mem = paddr >= `LCDSD_OFF_MEM && mem_rel[1:0] == 2'b00
      && int'(mem_rel[7:2]) < MEM_WORDS;
   wire mapped = hit_ctrl || hit_pinsel || hit_status || hit_mem;
   wire [31:0] status_word = {28'h0000000, half, slot, ladder_supply_out};

   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = hit_ctrl ? {24'h000000, ctrl}
      : hit_pinsel ? {25'h0, pin_function_select}
      : hit_status ? status_word
      : hit_mem ? mem[mem_rel[7:2]]
      : 32'h00000000;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl <= `LCDSD_CTRL_RST;
         pin_function_select <= `LCDSD_PINSEL_RST;
      end
      else
      begin
         if (wr && hit_ctrl)
            ctrl <= pwdata[7:0];
         if (wr && hit_pinsel)
            pin_function_select <= pwdata[6:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         mem <= '0;
      else if (wr && hit_mem)
         mem[mem_rel[7:2]] <= pwdata;
   end

   // ==========================================================
   // Pin function selection
   wire [5:0] lcd_seg_count = (ctrl.segment_port_group_select == 3'h0) ? 6'h00
      : 6'(`LCDSD_FIRST_GROUP_SEGS + `LCDSD_GROUP_STEP *
      (int'(ctrl.segment_port_group_select) - 1));

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SEG; gi++)
      begin : g_pin
         if (gi >= SHARED_SEG)
         begin : g_ded
            assign segment_pin_lcd[gi] = 1'b1;
         end
         else
         begin : g_shr
            assign segment_pin_lcd[gi] = gi < int'(lcd_seg_count);
         end
      end
   endgenerate

   assign common_pin_lcd = pin_function_select[3:0];
   assign tap_pin_lcd = pin_function_select[6:4];

   // ==========================================================
   // Frame timing
   wire run = ctrl.display_module_on && !ctrl.oscillator_disable;
   wire tick = frame_timing_clock && !ftc_q;
   logic [1:0] last_slot;

   always_comb
   begin
      unique case (ctrl.mux_rate_select)
         2'b00: last_slot = 2'd0;
         2'b01: last_slot = 2'd1;
         2'b10: last_slot = 2'd2;
         2'b11: last_slot = 2'd3;
      endcase
   end

   wire frame_end = slot >= last_slot;
   wire [1:0] next_slot = !run ? 2'd0 : !tick ? slot
      : frame_end ? 2'd0 : slot + 2'd1;
   wire next_half = !run ? 1'b0 : (tick && frame_end) ? !half : half;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ftc_q <= 1'b0;
         slot <= 2'd0;
         half <= 1'b0;
      end
      else
      begin
         ftc_q <= frame_timing_clock;
         slot <= next_slot;
         half <= next_half;
      end
   end

   // ==========================================================
   // Drive level table
   lcdsd_pkg::lcdsd_pair_t pair_a, pair_b, pair_c, pair_d;
   lcdsd_pkg::lcdsd_pair_t pair_seg_off, pair_com_idle;

   // In three- and four-mux, unselected commons and unlit segments sit on opposite inner levels, so an
   // unlit cell never sees more than one bias step.
   always_comb
   begin
      pair_a = '{lcdsd_pkg::LCDSD_LV_V5, lcdsd_pkg::LCDSD_LV_V1};
      pair_d = '{lcdsd_pkg::LCDSD_LV_V1, lcdsd_pkg::LCDSD_LV_V5};
      unique case (ctrl.mux_rate_select)
         2'b00:
         begin
            pair_b = '{lcdsd_pkg::LCDSD_LV_V1, lcdsd_pkg::LCDSD_LV_V5};
            pair_c = '{lcdsd_pkg::LCDSD_LV_V5, lcdsd_pkg::LCDSD_LV_V1};
            pair_seg_off = pair_c;
            pair_com_idle = pair_c;
         end
         2'b01:
         begin
            pair_b = '{lcdsd_pkg::LCDSD_LV_V1, lcdsd_pkg::LCDSD_LV_V5};
            pair_c = '{lcdsd_pkg::LCDSD_LV_V3, lcdsd_pkg::LCDSD_LV_V3};
            pair_seg_off = pair_a;
            pair_com_idle = pair_c;
         end
         default:
         begin
            pair_b = '{lcdsd_pkg::LCDSD_LV_V2, lcdsd_pkg::LCDSD_LV_V4};
            pair_c = '{lcdsd_pkg::LCDSD_LV_V4, lcdsd_pkg::LCDSD_LV_V2};
            pair_seg_off = pair_c;
            pair_com_idle = pair_b;
         end
      endcase
   end

   function automatic lcdsd_pkg::lcdsd_level_t pick(lcdsd_pkg::lcdsd_pair_t p, logic h, logic en);
      if (!en)
         return lcdsd_pkg::LCDSD_LV_ZERO;
      return h ? p.second : p.first;
   endfunction

   lcdsd_pkg::lcdsd_drive_t next_drive;
   lcdsd_pkg::lcdsd_level_t [3:0] next_common;
   lcdsd_pkg::lcdsd_level_t [NUM_SEG-1:0] next_segment;

   always_comb
   begin
      next_drive.level_a = pick(pair_a, half, run);
      next_drive.level_b = pick(pair_b, half, run);
      next_drive.level_c = pick(pair_c, half, run);
      next_drive.level_d = pick(pair_d, half, run);
   end

   // Unused commons rest at zero so the glass sees no stray field.
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_com
         wire active = run && (2'(gi) <= last_slot);
         wire lcdsd_pkg::lcdsd_pair_t cp = (2'(gi) == slot) ? pair_a : pair_com_idle;
         assign next_common[gi] = pick(cp, half, active);
      end
      for (gi = 0; gi < NUM_SEG; gi++)
      begin : g_seg
         wire [3:0] nib = mem[(gi * 4) / 32][(gi * 4) % 32 +: 4];
         wire seg_on = nib[slot] && ctrl.segments_global_on;
         wire lcdsd_pkg::lcdsd_pair_t sp = seg_on ? pair_d : pair_seg_off;
         assign next_segment[gi] = pick(sp, half, run);
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ladder_supply_out <= 1'b0;
         drive_levels <= '0;
         common_level <= '0;
         segment_level <= '0;
      end
      else
      begin
         ladder_supply_out <= run;
         drive_levels <= next_drive;
         common_level <= next_common;
         segment_level <= next_segment;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   wire seg0_bit = mem[0][slot];

   supply_off_a: assert property (!run |=> !ladder_supply_out
      && drive_levels == '0 && common_level == '0)
      else $error("supply or levels not off while idle");
   static_lvls_a: assert property (run && ctrl.mux_rate_select == 2'b00 && !half
      |=> drive_levels.level_b == lcdsd_pkg::LCDSD_LV_V1
      && drive_levels.level_c == lcdsd_pkg::LCDSD_LV_V5)
      else $error("static level table wrong");
   half_bias_a: assert property (run && ctrl.mux_rate_select == 2'b01
      |=> drive_levels.level_c == lcdsd_pkg::LCDSD_LV_V3)
      else $error("half bias midpoint wrong");
   third_bias_a: assert property (run && ctrl.mux_rate_select[1] && half
      |=> drive_levels.level_b == lcdsd_pkg::LCDSD_LV_V4
      && drive_levels.level_a == lcdsd_pkg::LCDSD_LV_V1)
      else $error("third bias table wrong");
   seg_on_a: assert property (run && seg0_bit && ctrl.segments_global_on
      |=> segment_level[0] == $past(pick(pair_d, half, 1'b1)))
      else $error("set segment not driven on");
   blank_segs_a: assert property (run && !ctrl.segments_global_on
      |=> segment_level[0] == $past(pick(pair_seg_off, half, 1'b1)))
      else $error("blanked segment driven on");
   group_zero_a: assert property (ctrl.segment_port_group_select == 3'h0
      |-> segment_pin_lcd[SHARED_SEG-1:0] == '0)
      else $error("shared pin given to display at group zero");
   group_two_a: assert property (ctrl.segment_port_group_select == 3'h2
      |-> segment_pin_lcd[19:0] == '1 && segment_pin_lcd[SHARED_SEG-1:20] == '0)
      else $error("group two pin split wrong");
   dedicated_pin_a: assert property (segment_pin_lcd[NUM_SEG-1:SHARED_SEG] == '1)
      else $error("dedicated pin lost");
   static_com_a: assert property (run && ctrl.mux_rate_select == 2'b00
      |=> common_level[1] == lcdsd_pkg::LCDSD_LV_ZERO)
      else $error("extra common active in static");
   slot_hold_a: assert property (run && !tick && $stable(ctrl) |=> $stable(slot))
      else $error("timing moved without frame clock");
   half_swap_a: assert property (run && tick && frame_end |=> half != $past(half))
      else $error("frame half not swapped");
   supply_on_a: assert property (run |=> ladder_supply_out)
      else $error("supply not on while running");
   idle_reset_a: assert property (!run |=> slot == 2'd0 && !half)
      else $error("timing not cleared while idle");
   com_select_a: assert property (run && slot == 2'd0 && !half
      |=> common_level[0] == lcdsd_pkg::LCDSD_LV_V5)
      else $error("selected common level wrong");
   com_idle_a: assert property (run && ctrl.mux_rate_select[1] && slot != 2'd1 && !half
      |=> common_level[1] == lcdsd_pkg::LCDSD_LV_V2)
      else $error("unselected common not at upper bias level");
   seg_bias_a: assert property (run && ctrl.mux_rate_select[1] && !seg0_bit && !half
      |=> segment_level[0] == lcdsd_pkg::LCDSD_LV_V4)
      else $error("unlit segment not at lower bias level");
   two_mux_com_a: assert property (run && ctrl.mux_rate_select == 2'b01
      |=> common_level[2] == lcdsd_pkg::LCDSD_LV_ZERO
      && common_level[3] == lcdsd_pkg::LCDSD_LV_ZERO)
      else $error("extra common active in two-mux");
   three_mux_com_a: assert property (run && ctrl.mux_rate_select == 2'b10
      |=> common_level[2] != lcdsd_pkg::LCDSD_LV_ZERO
      && common_level[3] == lcdsd_pkg::LCDSD_LV_ZERO)
      else $error("three-mux common set wrong");
   four_mux_com_a: assert property (run && ctrl.mux_rate_select == 2'b11
      |=> common_level[3] != lcdsd_pkg::LCDSD_LV_ZERO)
      else $error("fourth common idle in four-mux");
   group_one_a: assert property (ctrl.segment_port_group_select == 3'h1
      |-> segment_pin_lcd[15:0] == '1 && segment_pin_lcd[SHARED_SEG-1:16] == '0)
      else $error("group one pin split wrong");
   half_hold_a: assert property (run && !tick |=> $stable(half))
      else $error("frame half moved without frame clock");
   slot_step_a: assert property (run && tick && !frame_end
      |=> slot == $past(slot) + 2'd1)
      else $error("slot did not advance on tick");
   frame_wrap_a: assert property (run && tick && frame_end |=> slot == 2'd0)
      else $error("slot did not wrap at frame end");
   ctrl_write_a: assert property (wr && hit_ctrl |=> ctrl == $past(pwdata[7:0]))
      else $error("control write lost");
   pinsel_write_a: assert property (wr && hit_pinsel
      |=> common_pin_lcd == $past(pwdata[3:0]) && tap_pin_lcd == $past(pwdata[6:4]))
      else $error("pin function write lost");
   mem_write_a: assert property (wr && paddr == `LCDSD_OFF_MEM
      |=> mem[0] == $past(pwdata))
      else $error("display memory write lost");
   unmapped_err_a: assert property (access && paddr == 8'h40 |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");

   static_run_c: cover property (run && ctrl.mux_rate_select == 2'b00 && tick);
   four_mux_frame_c: cover property (run && ctrl.mux_rate_select == 2'b11 && tick && slot == 2'd3);
   blank_c: cover property (run && !ctrl.segments_global_on ##1 ctrl.segments_global_on);
   two_mux_step_c: cover property (run && ctrl.mux_rate_select == 2'b01 && tick && !frame_end);
endmodule // lcdsd_top

// file: testbench/lcdsd_panel.sv
// Passive glass model that shows whether one segment cell is lit.
`timescale 1ns/1ps
module lcdsd_panel (
   input wire lcdsd_pkg::lcdsd_level_t com_level,
   input wire lcdsd_pkg::lcdsd_level_t seg_level,
   output logic lit
);
   int diff;
   // A cell turns dark unless it sees at least three ladder steps across it.
   assign diff = int'(com_level) - int'(seg_level);
   assign lit = (diff >= 3) || (diff <= -3);
endmodule // lcdsd_panel

// file: testbench/lcdsd_segment_driver_bench.sv
// Self-checking bench of the LCD segment driver.
`timescale 1ns/1ps
module lcdsd_segment_driver_bench;
   // ==========================================
   // Signals
   logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, frame_timing_clock = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ladder_supply_out, lit, err;
   lcdsd_pkg::lcdsd_drive_t drive_levels;
   lcdsd_pkg::lcdsd_level_t [3:0] common_level;
   lcdsd_pkg::lcdsd_level_t [31:0] segment_level;
   logic [3:0] common_pin_lcd;
   logic [2:0] tap_pin_lcd;
   logic [31:0] segment_pin_lcd;
   int fail_count = 0, samples_checked = 0, cycles = 0;
   lcdsd_top i_lcdsd_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_timing_clock(frame_timing_clock),
      .ladder_supply_out(ladder_supply_out), .drive_levels(drive_levels),
      .common_level(common_level), .segment_level(segment_level),
      .common_pin_lcd(common_pin_lcd), .tap_pin_lcd(tap_pin_lcd),
      .segment_pin_lcd(segment_pin_lcd));
   lcdsd_panel i_lcdsd_panel (.com_level(common_level[0]), .seg_level(segment_level[0]),
      .lit(lit));
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========================================
   // Shared tasks
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // Stopping the display first clears slot and half so each setup starts at slot 0.
   task automatic setup(input logic [7:0] ctrl);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, {24'h0, ctrl});
   endtask
   task automatic tick();
      @(posedge ref_clk);
      frame_timing_clock <= 1'b1;
      repeat (3) @(posedge ref_clk);
      frame_timing_clock <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      check(ladder_supply_out, 1'b0);
      check(32'(drive_levels), 32'h0);
      check(segment_pin_lcd, 32'hf000_0000);
      apb(1'b0, 8'h40, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      check(pready, 1'b1);
   endtask
   task automatic t_static();
      apb(1'b1, 8'h10, 32'h1);
      setup(8'h03);
      check(ladder_supply_out, 1'b1);
      check(32'(drive_levels), {3'd5, 3'd1, 3'd5, 3'd1});
      check(common_level[0], lcdsd_pkg::LCDSD_LV_V5);
      check(common_level[1], lcdsd_pkg::LCDSD_LV_ZERO);
      check(segment_level[0], lcdsd_pkg::LCDSD_LV_V1);
      check(segment_level[1], lcdsd_pkg::LCDSD_LV_V5);
      check(lit, 1'b1);
      tick();
      check(common_level[0], lcdsd_pkg::LCDSD_LV_V1);
      check(segment_level[0], lcdsd_pkg::LCDSD_LV_V5);
      setup(8'h01);
      check(segment_level[0], lcdsd_pkg::LCDSD_LV_V5);
      check(lit, 1'b0);
   endtask
   task automatic t_mux();
      setup(8'h07);
      check(drive_levels.level_c, lcdsd_pkg::LCDSD_LV_V3);
      check(common_level[1], lcdsd_pkg::LCDSD_LV_V3);
      check(common_level[2], lcdsd_pkg::LCDSD_LV_ZERO);
      tick();
      check(common_level[1], lcdsd_pkg::LCDSD_LV_V5);
      setup(8'h0b);
      check(drive_levels.level_b, lcdsd_pkg::LCDSD_LV_V2);
      check(common_level[2], lcdsd_pkg::LCDSD_LV_V2);
      check(common_level[3], lcdsd_pkg::LCDSD_LV_ZERO);
      setup(8'h0f);
      check(common_level[3], lcdsd_pkg::LCDSD_LV_V2);
      check(segment_level[0], lcdsd_pkg::LCDSD_LV_V1);
      check(lit, 1'b1);
      apb(1'b1, 8'h10, 32'h0);
      check(segment_level[0], lcdsd_pkg::LCDSD_LV_V4);
      check(lit, 1'b0);
      setup(8'h8f);
      check(ladder_supply_out, 1'b0);
      check(32'(drive_levels), 32'h0);
   endtask
   task automatic t_pins();
      logic [31:0] exp;
      for (int g = 0; g < 4; g++)
      begin
         apb(1'b1, 8'h00, 32'(g << 4));
         exp = (g == 0) ? 32'h0 : ((32'h1 << (16 + 4 * (g - 1))) - 32'h1);
         check(segment_pin_lcd, exp | 32'hf000_0000);
      end
      check(segment_pin_lcd[15:0], 16'hffff);
      check(segment_pin_lcd[31:28], 4'hf);
      apb(1'b1, 8'h04, 32'h5a);
      check(common_pin_lcd, 4'ha);
      check(tap_pin_lcd, 3'h5);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h5a);
      check(err, 1'b0);
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_static();
      t_mux();
      t_pins();
      complete_run();
   end
endmodule // lcdsd_segment_driver_bench
